/* File: common/wps_pkg.sv */
/*
  wps_pkg: shared constants and types of the watchdog and power-fail reset supervisor.
  Assumes a 100 MHz pclk and an APB register port with byte addresses on paddr.
*/
package wps_pkg;

  // register byte offsets on the APB port
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_CLK = 8'h04;
  localparam logic [7:0] ADDR_PMG = 8'h08;
  localparam logic [7:0] ADDR_TA = 8'h0C;
  localparam logic [7:0] ADDR_IEN = 8'h10;
  localparam logic [7:0] ADDR_STAT = 8'h14;

  // supervisor_ctrl_reg bit positions
  localparam int B_POR = 6;
  localparam int B_PFIE = 5;
  localparam int B_PFW = 4;
  localparam int B_WIF = 3;
  localparam int B_WRF = 2;
  localparam int B_WRE = 1;
  localparam int B_RST = 0;
  // clock_ctrl_reg, power_mgmt_reg and irq enable field positions
  localparam int B_SEL = 6;
  localparam int B_CD = 6;
  localparam int B_MULT = 3;
  localparam int B_WIE = 0;

  // values after reset
  localparam logic [1:0] RST_SEL = 2'h0;
  localparam logic [1:0] RST_CD = 2'h2;
  localparam logic RST_MULT = 1'b0;

  // timed access unlock
  localparam logic [7:0] TA_KEY1 = 8'hAA;
  localparam logic [7:0] TA_KEY2 = 8'h55;
  localparam int CLK_PER_MC = 4;
  localparam int TA_WIN_MC = 3;
  localparam int TA_WIN_CYC = TA_WIN_MC * CLK_PER_MC;

  // watchdog time-out exponents (time-out is 2**exp clocks)
  localparam int EXP_FAST = 15;
  localparam int EXP_SLOW = 16;
  localparam int EXP_DIV = 17;
  localparam int EXP_DIV3 = 25;
  localparam int EXP_STEP = 3;
  localparam int WD_W = 35;
  localparam int GAP_CYC = 512;
  localparam int GAP_W = 10;

  // reset output timing
  localparam int WD_PULSE_MC = 2;
  localparam int WD_PULSE_CYC = WD_PULSE_MC * CLK_PER_MC;
  localparam int PWR_WAIT_CYC = 65536;
  localparam int SEQ_W = 17;

  // interrupt vectors and the fetch address after reset
  localparam logic [7:0] VEC_PFAIL = 8'h33;
  localparam logic [7:0] VEC_WDOG = 8'h63;
  localparam logic [15:0] RESET_VECTOR = 16'h0000;

  // synchronised pin indices
  localparam int N_PINS = 4;
  localparam int PIN_EXT = 0;
  localparam int PIN_LOW = 1;
  localparam int PIN_WARN = 2;
  localparam int PIN_OSC = 3;

  typedef enum logic [2:0] {
    S_RUN = 3'b000,
    S_HOLD = 3'b001,
    S_WAIT = 3'b010,
    S_WDRST = 3'b011,
    S_EXTRST = 3'b100
  } wps_state_t;

endpackage

/* File: verilog/wps_pin_sync.sv */
/*
  wps_pin_sync: three-stage synchroniser with agreement filter for the supervisor pins.
  Assumes pins are asynchronous levels that stay put for several pclk periods.
*/
`timescale 1ns/1ns
module wps_pin_sync import wps_pkg::*; (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [N_PINS-1:0] pin_in,
  output logic [N_PINS-1:0] pin_q
);

  typedef struct packed {
    logic [N_PINS-1:0] s1;
    logic [N_PINS-1:0] s2;
    logic [N_PINS-1:0] s3;
    logic [N_PINS-1:0] val;
  } wps_sync_st_t;

  wps_sync_st_t st_q;
  wps_sync_st_t st_d;

  // only stage two reads stage one; a bit changes once stages two and three agree
  always_comb begin
    st_d = st_q;
    st_d.s1 = pin_in;
    st_d.s2 = st_q.s1;
    st_d.s3 = st_q.s2;
    for (int i = 0; i < N_PINS; i++) begin
      if (st_q.s2[i] == st_q.s3[i]) begin
        st_d.val[i] = st_q.s3[i];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign pin_q = st_q.val;

endmodule

/* File: verilog/wps_top.sv */
/*
  wps_top: watchdog, power-fail and reset supervisor with an APB register port.
  Assumes pin inputs are asynchronous, presetn marks power-on, and the core obeys core_reset.
*/
// Chosen here: the APB register port and the placing of the registers.
`timescale 1ns/1ns
// Notes on behaviour
// - time-out select is bits 7:6 of the clock control register
// - interrupt time-out is two to the power of a base plus three per select step
// - divider field moves the base exponent, the multiplier bit only when the divider is zero, scaling every time-out
// - watchdog counter runs freely; timed restart returns it to zero
// - full count sets the watchdog interrupt flag
// - reset flag sets exactly 512 clocks after the interrupt flag
// - reset flag resets the core only when reset enable is one
// - reset enable and restart writes need the timed access window
// - watchdog interrupt has its own enable, apart from reset enable
// - enabled watchdog interrupt raises a wake request
// - core held while supply low, then 65,536 clocks before fetching address zero
// - power-on flag set after power-on; software reads then clears it
// - enabled power-fail warning requests vector 33h ahead of other sources
// - power-fail interrupt enable bit 5 enables or disables that interrupt
// - power-fail flag bit 4 sets on warning regardless of enable, cleared by software
// - reset output low on external pin, watchdog, oscillator fail or power fail
// - reset output low 65536 clocks long resets, 2 machine cycles watchdog
module wps_top import wps_pkg::*; #(
  parameter int POWER_WAIT = PWR_WAIT_CYC,
  parameter int WDOG_EXP_TRIM = 0
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic ext_reset,
  input wire logic supply_low,
  input wire logic supply_warn,
  input wire logic osc_fail,
  output logic reset_out_n,
  output logic core_reset,
  output logic irq_req,
  output logic [7:0] irq_vector,
  output logic wake_req
);

  typedef struct packed {
    wps_state_t state;
    logic [SEQ_W-1:0] seq_cnt;
    logic [WD_W-1:0] wd_cnt;
    logic [GAP_W-1:0] gap_cnt;
    logic gap_pend;
    logic ta_stage;
    logic [3:0] ta_win;
    logic [1:0] timeout_select;
    logic [1:0] clock_divider_sel;
    logic clock_multiplier_sel;
    logic por;
    logic power_fail_irq_enable;
    logic power_fail_warning;
    logic wdog_irq_flag;
    logic wdog_reset_flag;
    logic wdog_reset_enable;
    logic wdog_irq_enable;
    logic warn_seen;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic rst_out_n;
    logic core_rst;
    logic irq_req;
    logic wake;
    logic [7:0] irq_vec;
  } wps_st_t;

  localparam logic [GAP_W-1:0] GAP_LOAD = GAP_W'(GAP_CYC - 1);

  wps_st_t st_q;
  wps_st_t st_d;
  logic [N_PINS-1:0] pin_s;
  logic acc;
  logic acc_wr;
  logic wr_ctrl;
  logic prot_ok;
  logic restart_ev;
  logic wd_full;
  logic gap_done;
  logic warn_rise;
  logic run;
  logic quiet_pins;
  logic [1:0] sel_wr;
  logic [5:0] wd_exp_now;

  // time-out exponent from clock settings and select field
  function automatic logic [5:0] wd_exp(input logic mult, input logic [1:0] cd, input logic [1:0] sel);
    logic [5:0] b;
    b = 6'(EXP_DIV);
    case (cd)
      2'h0: b = mult ? 6'(EXP_FAST) : 6'(EXP_SLOW);
      2'h3: b = 6'(EXP_DIV3);
      default: b = 6'(EXP_DIV);
    endcase
    return b + 6'(EXP_STEP) * {4'h0, sel} - 6'(WDOG_EXP_TRIM);
  endfunction

  // low exp bits all ones: the chain has completed 2**exp clocks
  function automatic logic is_full(input logic [WD_W-1:0] cnt, input logic [5:0] e);
    logic [WD_W-1:0] mask;
    mask = (WD_W'(1) << e) - WD_W'(1);
    return (cnt & mask) == mask;
  endfunction

  wps_pin_sync u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .pin_in({osc_fail, supply_warn, supply_low, ext_reset}),
    .pin_q(pin_s)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // decode helpers
  assign acc = psel & penable & st_q.pready;
  assign acc_wr = acc & pwrite & ~st_q.pslverr;
  assign wr_ctrl = acc_wr & (paddr == ADDR_CTRL);
  assign prot_ok = st_q.ta_win != 4'h0;
  assign restart_ev = wr_ctrl & prot_ok & pwdata[B_RST];
  assign wd_exp_now = wd_exp(st_q.clock_multiplier_sel, st_q.clock_divider_sel, st_q.timeout_select);
  assign wd_full = is_full(st_q.wd_cnt, wd_exp_now);
  assign gap_done = st_q.gap_pend & (st_q.gap_cnt == '0);
  assign warn_rise = pin_s[PIN_WARN] & ~st_q.warn_seen;
  assign run = st_q.state == S_RUN;
  assign quiet_pins = ~pin_s[PIN_LOW] & ~pin_s[PIN_OSC] & ~pin_s[PIN_EXT];
  assign sel_wr = pwdata[B_SEL+:2];

  ////////////////////////////////////////////////////////////////////////////////
  // next state: bus writes first, so hardware sets placed later win over clears
  always_comb begin
    st_d = st_q;
    // two-cycle access: pready rises one cycle into the access phase
    st_d.pready = psel & penable & ~st_q.pready;
    st_d.pslverr = 1'b0;
    if (psel & penable & ~st_q.pready) begin
      case (paddr)
        ADDR_CTRL: st_d.prdata = {25'h0, st_q.por, st_q.power_fail_irq_enable, st_q.power_fail_warning,
          st_q.wdog_irq_flag, st_q.wdog_reset_flag, st_q.wdog_reset_enable, 1'b0};
        ADDR_CLK: st_d.prdata = {24'h0, st_q.timeout_select, 6'h00};
        ADDR_PMG: st_d.prdata = {24'h0, st_q.clock_divider_sel, 2'h0, st_q.clock_multiplier_sel, 3'h0};
        ADDR_TA: st_d.prdata = 32'h0;
        ADDR_IEN: st_d.prdata = {31'h0, st_q.wdog_irq_enable};
        ADDR_STAT: st_d.prdata = {27'h0, st_q.core_rst, st_q.gap_pend, st_q.state};
        default: begin
          st_d.prdata = 32'h0;
          st_d.pslverr = 1'b1;
        end
      endcase
    end
    if (acc) begin
      st_d.pslverr = 1'b0;
    end
    if (prot_ok) begin
      st_d.ta_win = st_q.ta_win - 4'h1;
    end

    // register writes; any other write without pslverr breaks the unlock pair
    if (acc_wr) begin
      st_d.ta_stage = 1'b0;
      case (paddr)
        ADDR_CLK: st_d.timeout_select = sel_wr;
        ADDR_PMG: begin
          st_d.clock_divider_sel = pwdata[B_CD+:2];
          st_d.clock_multiplier_sel = pwdata[B_MULT];
        end
        ADDR_IEN: st_d.wdog_irq_enable = pwdata[B_WIE];
        ADDR_CTRL: begin
          st_d.power_fail_irq_enable = pwdata[B_PFIE];
          st_d.power_fail_warning = pwdata[B_PFW];
          st_d.wdog_reset_flag = pwdata[B_WRF];
          // one protected write per unlock, then the window closes
          if (prot_ok) begin
            st_d.por = pwdata[B_POR];
            st_d.wdog_irq_flag = pwdata[B_WIF];
            st_d.wdog_reset_enable = pwdata[B_WRE];
            st_d.ta_win = 4'h0;
          end
        end
        ADDR_TA: begin
          if (pwdata[7:0] == TA_KEY1) begin
            st_d.ta_stage = 1'b1;
          end else if (st_q.ta_stage && pwdata[7:0] == TA_KEY2) begin
            st_d.ta_win = 4'(TA_WIN_CYC);
          end
        end
        default: st_d.ta_stage = 1'b0;
      endcase
    end

    // free-running chain; the gap counter times the last 512 clocks
    st_d.wd_cnt = st_q.wd_cnt + WD_W'(1);
    if (st_q.gap_pend) begin
      st_d.gap_cnt = st_q.gap_cnt - GAP_W'(1);
    end
    if (wd_full && !st_q.gap_pend) begin
      st_d.wdog_irq_flag = 1'b1;
      st_d.gap_pend = 1'b1;
      st_d.gap_cnt = GAP_LOAD;
    end
    if (gap_done) begin
      st_d.wdog_reset_flag = 1'b1;
      st_d.gap_pend = 1'b0;
    end
    // restart and any reset period start the full time-out again
    if (restart_ev || !run) begin
      st_d.wd_cnt = '0;
      st_d.gap_pend = 1'b0;
    end

    // warning is caught on its edge so software can clear it while supply stays low
    st_d.warn_seen = pin_s[PIN_WARN];
    if (warn_rise) begin
      st_d.power_fail_warning = 1'b1;
    end

    // reset sequencer
    case (st_q.state)
      S_RUN: begin
        if (gap_done && st_q.wdog_reset_enable) begin
          st_d.state = S_WDRST;
          st_d.seq_cnt = SEQ_W'(WD_PULSE_CYC - 1);
        end
      end
      S_WAIT, S_WDRST: begin
        if (st_q.seq_cnt == '0) begin
          st_d.state = S_RUN;
        end else begin
          st_d.seq_cnt = st_q.seq_cnt - SEQ_W'(1);
        end
      end
      S_HOLD: begin
        if (!pin_s[PIN_LOW]) begin
          st_d.state = S_WAIT;
          st_d.seq_cnt = SEQ_W'(POWER_WAIT - 1);
        end
      end
      S_EXTRST: begin
        if (!pin_s[PIN_EXT]) begin
          st_d.state = S_RUN;
        end
      end
      default: st_d.state = S_HOLD;
    endcase
    // a failed oscillator keeps reloading the long wait until it recovers
    if (pin_s[PIN_EXT] && (st_q.state == S_RUN || st_q.state == S_WDRST)) begin
      st_d.state = S_EXTRST;
    end
    if (pin_s[PIN_OSC] && st_q.state != S_HOLD) begin
      st_d.state = S_WAIT;
      st_d.seq_cnt = SEQ_W'(POWER_WAIT - 1);
    end
    if (pin_s[PIN_LOW]) begin
      st_d.state = S_HOLD;
      st_d.por = 1'b1;
    end

    // outputs follow the next state so they leave the flops aligned with it
    st_d.rst_out_n = st_d.state == S_RUN;
    st_d.core_rst = st_d.state != S_RUN;
    st_d.irq_req = (st_d.state == S_RUN) && ((st_d.power_fail_warning && st_d.power_fail_irq_enable) ||
      (st_d.wdog_irq_flag && st_d.wdog_irq_enable));
    st_d.irq_vec = (st_d.power_fail_warning && st_d.power_fail_irq_enable) ? VEC_PFAIL : VEC_WDOG;
    st_d.wake = st_d.wdog_irq_flag && st_d.wdog_irq_enable;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // state register; presetn counts as a power-on
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= '0;
      st_q.state <= S_WAIT;
      st_q.seq_cnt <= SEQ_W'(POWER_WAIT - 1);
      st_q.por <= 1'b1;
      st_q.timeout_select <= RST_SEL;
      st_q.clock_divider_sel <= RST_CD;
      st_q.clock_multiplier_sel <= RST_MULT;
      st_q.core_rst <= 1'b1;
      st_q.irq_vec <= VEC_WDOG;
    end else begin
      st_q <= st_d;
    end
  end

  // the core starts fetching at RESET_VECTOR when core_reset falls
  assign prdata = st_q.prdata;
  assign pready = st_q.pready;
  assign pslverr = st_q.pslverr;
  assign reset_out_n = st_q.rst_out_n;
  assign core_reset = st_q.core_rst;
  assign irq_req = st_q.irq_req;
  assign irq_vector = st_q.irq_vec;
  assign wake_req = st_q.wake;

  ////////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence wd_entry;
    run ##1 (st_q.state == S_WDRST);
  endsequence

  chk_sel_field: assert property ((acc_wr && paddr == ADDR_CLK) |=> st_q.timeout_select == $past(sel_wr))
    else $error("time-out select not taken");
  chk_irq_timeout: assert property ((run && wd_full && !st_q.gap_pend && !restart_ev) |=>
    (st_q.wdog_irq_flag && st_q.gap_pend))
    else $error("full count did not set irq flag");
  chk_gap_load: assert property ($rose(st_q.gap_pend) |-> st_q.gap_cnt == GAP_LOAD)
    else $error("gap not loaded with 511");
  chk_gap_end: assert property ((run && gap_done) |=> st_q.wdog_reset_flag && !st_q.gap_pend)
    else $error("reset flag not set at gap end");
  chk_wdog_reset: assert property ((run && gap_done && st_q.wdog_reset_enable && quiet_pins) |=>
    (st_q.state == S_WDRST && !st_q.rst_out_n && st_q.core_rst))
    else $error("enabled watchdog reset missing");
  chk_no_reset: assert property ((run && gap_done && !st_q.wdog_reset_enable && quiet_pins) |=> run)
    else $error("reset taken while disabled");
  chk_ta_guard: assert property ((wr_ctrl && !prot_ok) |=> $stable(st_q.wdog_reset_enable))
    else $error("unprotected write changed reset enable");
  chk_restart_clear: assert property ((run && restart_ev) |=> (st_q.wd_cnt == '0 && !st_q.gap_pend))
    else $error("restart did not clear chain");
  chk_pf_flag: assert property (warn_rise |=> st_q.power_fail_warning)
    else $error("warning did not set flag");
  chk_supply_hold: assert property (pin_s[PIN_LOW] |=> (st_q.state == S_HOLD && st_q.core_rst && st_q.por))
    else $error("core not held on low supply");
  chk_wd_pulse: assert property (wd_entry |-> (!st_q.rst_out_n) [*8])
    else $error("watchdog reset pulse too short");
  chk_pf_vector: assert property ((st_q.irq_req && st_q.power_fail_warning && st_q.power_fail_irq_enable) |->
    st_q.irq_vec == VEC_PFAIL)
    else $error("power-fail vector not first");

endmodule

/* File: verif/wps_board_model.sv */
/*
  wps_board_model: board pins around the supervisor: reset button, supply monitor and oscillator detector.
  Assumes the bench asks for one pulse at a time through go, kind and len.
*/
`timescale 1ns/1ns
module wps_board_model (
  input wire logic pclk,
  input wire logic go,
  input wire logic [1:0] kind,
  input wire logic [15:0] len,
  output logic ext_reset,
  output logic supply_low,
  output logic supply_warn,
  output logic osc_fail
);
  logic [15:0] left_q = 16'h0000;
  logic [1:0] kind_q = 2'h0;

  //////////////////////////////////////////////////////////////////////////////
  // one pin high for len clocks; pulses far longer than the sync filter
  always @(posedge pclk) begin
    if (go) begin
      left_q <= len;
      kind_q <= kind;
    end else if (left_q != 16'h0000) begin
      left_q <= left_q - 16'h0001;
    end
  end

  // all pins rest low: the board pulls them down between events
  assign ext_reset = (left_q != 16'h0000) && (kind_q == 2'h0);
  assign supply_low = (left_q != 16'h0000) && (kind_q == 2'h1);
  assign supply_warn = (left_q != 16'h0000) && (kind_q == 2'h2);
  assign osc_fail = (left_q != 16'h0000) && (kind_q == 2'h3);
endmodule

/* File: verif/tb.sv */
/*
  tb: self-checking bench for wps_top through its APB port and the board pin model.
  Assumes 100 MHz pclk; power wait and watchdog counts are shortened by parameters.
*/
`timescale 1ns/1ns
module tb import wps_pkg::*;;
  localparam int PW = 20;
  localparam int TRIM = 10;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, reset_out_n, core_reset, irq_req, wake_req;
  logic ext_reset, supply_low, supply_warn, osc_fail;
  logic [7:0] irq_vector;
  logic go = 1'b0;
  logic [1:0] kind = 2'h0;
  logic [15:0] len = 16'h0;
  logic [2:0] mon;
  logic [31:0] rd;
  logic err;
  logic [7:0] vec;
  int num_errors = 0;
  int checks_done = 0;
  int n, n0;
  // table of {divider, multiplier, select}
  logic [4:0] cfg [8] = '{5'b00100, 5'b00101, 5'b00000, 5'b01000, 5'b10000, 5'b11000, 5'b00110, 5'b00111};

  wps_top #(.POWER_WAIT(PW), .WDOG_EXP_TRIM(TRIM)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .ext_reset(ext_reset), .supply_low(supply_low), .supply_warn(supply_warn),
    .osc_fail(osc_fail), .reset_out_n(reset_out_n), .core_reset(core_reset), .irq_req(irq_req),
    .irq_vector(irq_vector), .wake_req(wake_req));
  wps_board_model board (.pclk(pclk), .go(go), .kind(kind), .len(len), .ext_reset(ext_reset),
    .supply_low(supply_low), .supply_warn(supply_warn), .osc_fail(osc_fail));
  assign mon = {irq_req, reset_out_n, wake_req};

  //////////////////////////////////////////////////////////////////////////////
  // clock, 10 ns period
  initial begin
    forever #5 pclk = ~pclk;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // one APB transfer; entered just after a rising edge, leaves one idle cycle
  task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] d);
    int k;
    k = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    // read before this edge's updates: these are the values the slave shows at the edge
    while (pready !== 1'b1 && k < 20) begin
      k++;
      @(posedge pclk);
    end
    if (k >= 20) begin
      chk(32'h0, 32'h1);
      tally_and_finish();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    apb(1'b0, a, 8'h00);
    chk(rd & m, e);
  endtask

  // unlock, then one write to the control register inside the window
  task automatic ta_wr(input logic [7:0] d);
    apb(1'b1, ADDR_TA, TA_KEY1);
    apb(1'b1, ADDR_TA, TA_KEY2);
    apb(1'b1, ADDR_CTRL, d);
  endtask

  // counts falling edges until the watched output reaches lvl; bounded, returns lim on timeout
  // with must set, a level that never comes is a mismatch and ends the run
  task automatic wait_on(input int w, input logic lvl, input int lim, input bit must, output int c);
    c = 0;
    @(negedge pclk);
    while (mon[w] !== lvl && c < lim) begin
      c++;
      @(negedge pclk);
    end
    vec = irq_vector;
    if (must && c >= lim) begin
      chk(32'h0, 32'h1);
      tally_and_finish();
    end
    @(posedge pclk);
  endtask

  task automatic pulse(input logic [1:0] k, input logic [15:0] l);
    kind <= k;
    len <= l;
    go <= 1'b1;
    @(posedge pclk);
    go <= 1'b0;
  endtask

  function automatic int texp(input logic [4:0] c);
    int e;
    e = (c[4:3] == 2'h0) ? (c[2] ? 15 : 16) : ((c[4:3] == 2'h3) ? 25 : 17);
    return 1 << (e - TRIM + 3 * c[1:0]);
  endfunction

  task automatic tally_and_finish;
    $display("errors=%0d checks=%0d", num_errors, checks_done);
    if (num_errors == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  //////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    wait_on(1, 1'b1, 100, 1'b1, n);
    chk(32'(n inside {[PW - 1:PW + 6]}), 32'h1);
    rd_chk(ADDR_CTRL, 32'hFFFFFFFF, 32'h40);
    rd_chk(ADDR_CLK, 32'hFFFFFFFF, 32'h0);
    rd_chk(ADDR_PMG, 32'hFFFFFFFF, 32'h80);
    apb(1'b0, 8'h18, 8'h00);
    chk({rd[30:0], err}, 32'h1);
    // protected bits refuse plain writes and a broken unlock
    apb(1'b1, ADDR_CTRL, 8'h02);
    rd_chk(ADDR_CTRL, 32'hFFFFFFFF, 32'h40);
    apb(1'b1, ADDR_TA, TA_KEY1);
    apb(1'b1, ADDR_CLK, 8'h00);
    apb(1'b1, ADDR_TA, TA_KEY2);
    apb(1'b1, ADDR_CTRL, 8'h00);
    rd_chk(ADDR_CTRL, 32'hFFFFFFFF, 32'h40);
    ta_wr(8'h00);
    rd_chk(ADDR_CTRL, 32'hFFFFFFFF, 32'h0);
    // time-out of every select, divider and multiplier setting, relative to the shortest
    apb(1'b1, ADDR_IEN, 8'h01);
    for (int i = 0; i < 8; i++) begin
      apb(1'b1, ADDR_PMG, {cfg[i][4:3], 2'b00, cfg[i][2], 3'b000});
      apb(1'b1, ADDR_CLK, {cfg[i][1:0], 6'h00});
      ta_wr(8'h01);
      wait_on(0, 1'b1, 40000, 1'b1, n);
      if (i == 0) n0 = n;
      chk(32'(n - n0), 32'(texp(cfg[i]) - 32));
    end
    chk(32'(n0 inside {[26:36]}), 32'h1);
    wait_on(1, 1'b0, 600, 1'b0, n);
    chk(32'(n), 32'd600);
    apb(1'b1, ADDR_IEN, 8'h00);
    wait_on(0, 1'b1, 5, 1'b0, n);
    chk(32'(n), 32'd5);
    apb(1'b1, ADDR_IEN, 8'h01);
    // power-fail flag, enable and vector priority over a pending watchdog request
    pulse(2'h2, 16'd8);
    repeat (8) @(posedge pclk);
    rd_chk(ADDR_CTRL, 32'h30, 32'h10);
    wait_on(2, 1'b1, 5, 1'b1, n);
    chk({24'h0, vec}, {24'h0, VEC_WDOG});
    apb(1'b1, ADDR_CTRL, 8'h30);
    wait_on(2, 1'b1, 5, 1'b1, n);
    chk({24'h0, vec}, {24'h0, VEC_PFAIL});
    apb(1'b1, ADDR_CTRL, 8'h20);
    rd_chk(ADDR_CTRL, 32'h30, 32'h20);
    wait_on(2, 1'b1, 5, 1'b1, n);
    chk({24'h0, vec}, {24'h0, VEC_WDOG});
    // restart inside the gap cancels it; then a full time-out resets
    apb(1'b1, ADDR_CTRL, 8'h00);
    ta_wr(8'h03);
    wait_on(0, 1'b1, 20000, 1'b1, n);
    wait_on(1, 1'b0, 100, 1'b0, n);
    chk(32'(n), 32'd100);
    ta_wr(8'h03);
    wait_on(1, 1'b0, 600, 1'b0, n);
    chk(32'(n), 32'd600);
    wait_on(0, 1'b1, 20000, 1'b1, n);
    wait_on(1, 1'b0, 600, 1'b1, n);
    chk(32'(n + 1 inside {[511:513]}), 32'h1);
    wait_on(1, 1'b1, 50, 1'b1, n);
    chk(32'(n + 1), 32'(WD_PULSE_CYC));
    ta_wr(8'h00);
    // external, oscillator and supply resets
    pulse(2'h0, 16'd10);
    wait_on(1, 1'b0, 20, 1'b1, n);
    wait_on(1, 1'b1, 40, 1'b1, n);
    chk(32'(n + 1 inside {[8:13]}), 32'h1);
    pulse(2'h3, 16'd10);
    wait_on(1, 1'b0, 20, 1'b1, n);
    wait_on(1, 1'b1, 100, 1'b1, n);
    chk(32'(n + 1 inside {[PW + 8:PW + 16]}), 32'h1);
    pulse(2'h1, 16'd30);
    wait_on(1, 1'b0, 20, 1'b1, n);
    chk({31'h0, core_reset}, 32'h1);
    wait_on(1, 1'b1, 200, 1'b1, n);
    chk(32'(n + 1 inside {[PW + 28:PW + 36]}), 32'h1);
    chk({31'h0, core_reset}, 32'h0);
    rd_chk(ADDR_CTRL, 32'h40, 32'h40);
    tally_and_finish();
  end
endmodule
